// [hdl/pwmsy_top.sv]
// 16-bit waveform generator with offset sync, buffered reload and AXI4-Lite registers
`timescale 1ns/100ps
module pwmsy_top
  import pwmsy_pkg::*;
#(
  parameter int CW = 16
) (
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          srst,
  // AXI4-Lite write address
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // Sibling modules, same clock
  input  wire logic          group_start_bit,
  input  wire logic          master_offset_hit,
  output logic               offset_hit_event,
  output logic               load_event,
  // Waveform
  output logic               pwm_out
);

  // ==========================================================
  // Register state
  logic          en_q, pol_q;
  logic [1:0]    mode_q, ofm_q;
  logic          ofo_b_q, ofo_op_q, lda_q;
  logic [CW-1:0] ph_b_q, dc_b_q, pr_b_q, of_b_q;
  logic [CW-1:0] ph_q, dc_q, pr_q, of_q;
  logic [7:0]    psc_q, ps_cnt_q;
  logic [3:0]    flag_q, mprev_q;
  logic          sw_pend_q, sw_val_q;

  // Timer state
  logic [CW-1:0] tmr_q, tg_cnt_q;
  logic          down_q, run_q, act_q, hit_pend_q;

  // Bus state
  logic          aw_have_q, w_have_q;
  logic [7:0]    awaddr_q;
  logic [31:0]   wdata_q;
  logic [3:0]    wstrb_q;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a <= OFF_FLAGS) && (a[1:0] == 2'h0);
  endfunction

  // ==========================================================
  // Write path
  logic        wr_go;
  logic [31:0] cur_w, nv_w;
  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;

  always_comb begin
    case (awaddr_q)
      OFF_CTRL:   cur_w = {24'h0, en_q, 1'b0, act_q, pol_q, mode_q, 2'h0};
      OFF_OFCON:  cur_w = {27'h0, ofo_b_q, 2'h0, ofm_q};
      OFF_PHASE:  cur_w = 32'(ph_b_q);
      OFF_DUTY:   cur_w = 32'(dc_b_q);
      OFF_PERIOD: cur_w = 32'(pr_b_q);
      OFF_OFFSET: cur_w = 32'(of_b_q);
      OFF_CLKCON: cur_w = {24'h0, psc_q};
      default:    cur_w = 32'h0;
    endcase
  end
  assign nv_w = merge(cur_w, wdata_q, wstrb_q);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OK;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0;
      wstrb_q       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q     <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awaddr_q) ? RESP_OK : RESP_ERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_have_q     <= 1'b0;
        w_have_q      <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Read path
  logic [31:0] rd_w;
  always_comb begin
    case (s_axi_araddr)
      OFF_CTRL:   rd_w = {24'h0, en_q, 1'b0, act_q, pol_q, mode_q, 2'h0};
      OFF_OFCON:  rd_w = {27'h0, ofo_b_q, 2'h0, ofm_q};
      OFF_LDCON:  rd_w = {24'h0, lda_q, 7'h0};
      OFF_PHASE:  rd_w = 32'(ph_b_q);
      OFF_DUTY:   rd_w = 32'(dc_b_q);
      OFF_PERIOD: rd_w = 32'(pr_b_q);
      OFF_OFFSET: rd_w = 32'(of_b_q);
      OFF_TIMER:  rd_w = 32'(tmr_q);
      OFF_CLKCON: rd_w = {24'h0, psc_q};
      OFF_FLAGS:  rd_w = {28'h0, flag_q};
      default:    rd_w = 32'h0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_w;
      s_axi_rresp   <= mapped(s_axi_araddr) ? RESP_OK : RESP_ERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================
  // Timing and match decode
  logic          en_w, tick_w, prd_w, load_w;
  logic          ph_m, dc_m, of_m, cu_m, cd_m;
  logic [CW-1:0] cu_val;
  logic [3:0]    m_vec;

  assign en_w   = en_q || group_start_bit;
  assign tick_w = en_w && (ps_cnt_q >= psc_q);
  assign prd_w  = run_q && ((mode_q == MODE_CEN) ? (down_q && tmr_q == '0)
                                                 : (tmr_q >= pr_q));
  assign load_w = tick_w && prd_w && lda_q;
  assign cu_val = CW'(pr_q - dc_q);
  assign ph_m   = run_q && tmr_q == ph_q;
  assign dc_m   = run_q && tmr_q == dc_q;
  assign cu_m   = run_q && !down_q && tmr_q == cu_val;
  assign cd_m   = run_q && down_q && tmr_q == CW'(cu_val + 1'b1);
  assign of_m   = run_q && tmr_q == of_q &&
                  ((mode_q != MODE_CEN) || (down_q == ofo_op_q));
  assign m_vec  = {of_m, ph_m, dc_m, prd_w};

  always_ff @(posedge ref_clk) begin
    if (srst || !en_w || tick_w) begin
      ps_cnt_q <= 8'h00;
    end else begin
      ps_cnt_q <= ps_cnt_q + 8'h01;
    end
  end

  // ==========================================================
  // Control registers written by software
  logic wr_ctrl, wr_of, wr_ld;
  assign wr_ctrl = wr_go && awaddr_q == OFF_CTRL;
  assign wr_of   = wr_go && awaddr_q == OFF_OFCON;
  assign wr_ld   = wr_go && awaddr_q == OFF_LDCON && nv_w[LDCON_LDA_BIT];

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      en_q    <= 1'b0;
      pol_q   <= 1'b0;
      mode_q  <= MODE_STD;
      ofm_q   <= OFM_IND;
      ofo_b_q <= 1'b0;
      psc_q   <= PSC_RST;
      ph_b_q  <= CNT_RST;
      dc_b_q  <= CNT_RST;
      pr_b_q  <= CNT_RST;
      of_b_q  <= CNT_RST;
    end else if (wr_go) begin
      case (awaddr_q)
        OFF_CTRL: begin
          en_q   <= nv_w[CTRL_EN_BIT];
          pol_q  <= nv_w[CTRL_POL_BIT];
          mode_q <= nv_w[CTRL_MODE_LSB +: 2];
        end
        OFF_OFCON: begin
          ofm_q   <= nv_w[OFCON_OFM_LSB +: 2];
          ofo_b_q <= nv_w[OFCON_OFO_BIT];
        end
        OFF_PHASE:  ph_b_q <= nv_w[CW-1:0];
        OFF_DUTY:   dc_b_q <= nv_w[CW-1:0];
        OFF_PERIOD: pr_b_q <= nv_w[CW-1:0];
        OFF_OFFSET: of_b_q <= nv_w[CW-1:0];
        OFF_CLKCON: psc_q  <= nv_w[7:0];
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Buffered reload
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lda_q <= 1'b0;
    end else if (wr_ld) begin
      lda_q <= 1'b1;                                               // Set wins over load clear
    end else if (load_w) begin
      lda_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ph_q     <= CNT_RST;
      dc_q     <= CNT_RST;
      pr_q     <= CNT_RST;
      of_q     <= CNT_RST;
      ofo_op_q <= 1'b0;
    end else if (!en_w || load_w) begin
      ph_q     <= ph_b_q;
      dc_q     <= dc_b_q;
      pr_q     <= pr_b_q;
      of_q     <= of_b_q;
      ofo_op_q <= ofo_b_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      load_event <= 1'b0;
    end else begin
      load_event <= load_w;
    end
  end

  // ==========================================================
  // Offset sync
  // Master hit may fall between our ticks, so hold it until consumed
  always_ff @(posedge ref_clk) begin
    if (srst || !en_w) begin
      hit_pend_q <= 1'b0;
    end else if (master_offset_hit) begin
      hit_pend_q <= 1'b1;
    end else if (tick_w) begin
      hit_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || !en_w) begin
      run_q <= 1'b0;
    end else if (tick_w) begin
      case (ofm_q)
        OFM_IND:  run_q <= 1'b1;
        OFM_SYNC: run_q <= run_q || hit_pend_q;
        OFM_ONE:  run_q <= hit_pend_q || (run_q && !prd_w);
        OFM_CONT: run_q <= run_q || hit_pend_q;
        default:  run_q <= run_q;
      endcase
    end
  end

  // ==========================================================
  // Waveform timer
  always_ff @(posedge ref_clk) begin
    if (srst || !en_w) begin
      tmr_q  <= CNT_RST;
      down_q <= 1'b0;
    end else if (tick_w && run_q) begin
      if (ofm_q == OFM_CONT && hit_pend_q) begin
        tmr_q  <= CW'(1);
        down_q <= 1'b0;
      end else if (mode_q == MODE_CEN) begin
        if (prd_w) begin
          tmr_q  <= CW'(1);
          down_q <= 1'b0;
        end else if (!down_q && tmr_q >= pr_q) begin
          tmr_q  <= CW'(tmr_q - 1'b1);
          down_q <= 1'b1;
        end else if (down_q) begin
          tmr_q <= CW'(tmr_q - 1'b1);
        end else begin
          tmr_q <= CW'(tmr_q + 1'b1);
        end
      end else if (prd_w) begin
        tmr_q  <= CNT_RST;
        down_q <= 1'b0;
      end else begin
        tmr_q <= CW'(tmr_q + 1'b1);
      end
    end
  end

  // ==========================================================
  // Output level
  always_ff @(posedge ref_clk) begin
    if (srst || !en_w) begin
      tg_cnt_q <= CNT_RST;
    end else if (tick_w && prd_w) begin
      tg_cnt_q <= (tg_cnt_q >= ph_q) ? CNT_RST : CW'(tg_cnt_q + 1'b1);
    end
  end

  // Level writes only matter in set-on-match; other modes drop them
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sw_pend_q <= 1'b0;
      sw_val_q  <= 1'b0;
    end else if (wr_ctrl && mode_q == MODE_SOM && nv_w[CTRL_MODE_LSB +: 2] == MODE_SOM) begin
      sw_pend_q <= 1'b1;
      sw_val_q  <= nv_w[CTRL_OUT_BIT];
    end else if (tick_w) begin
      sw_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || !en_w) begin
      act_q <= 1'b0;
    end else if (tick_w) begin
      case (mode_q)
        MODE_STD: begin
          if (dc_m) begin
            act_q <= 1'b0;
          end else if (ph_m) begin
            act_q <= 1'b1;
          end
        end
        MODE_SOM: begin
          if (sw_pend_q) begin
            act_q <= sw_val_q;
          end else if (ph_m && tmr_q <= pr_q) begin
            act_q <= 1'b1;
          end
        end
        MODE_TOG: begin
          if (prd_w && tg_cnt_q >= ph_q) begin
            act_q <= !act_q;
          end
        end
        MODE_CEN: begin
          if (cu_m) begin
            act_q <= 1'b1;
          end else if (cd_m) begin
            act_q <= 1'b0;
          end
        end
        default: act_q <= act_q;
      endcase
    end
  end

  // Inversion sits after enable gating so it holds while disabled
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= act_q ^ pol_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      offset_hit_event <= 1'b0;
    end else begin
      offset_hit_event <= tick_w && of_m;
    end
  end

  // ==========================================================
  // Match flags, write one to clear, set wins
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mprev_q <= 4'h0;
    end else if (tick_w || !en_w) begin
      mprev_q <= tick_w ? m_vec : 4'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      flag_q <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (tick_w && m_vec[i] && !mprev_q[i]) begin
          flag_q[i] <= 1'b1;
        end else if (wr_go && awaddr_q == OFF_FLAGS && wstrb_q[0] && wdata_q[i]) begin
          flag_q[i] <= 1'b0;
        end
      end
    end
  end

endmodule

// [hdl/pwmsy_pkg.sv]
// Package with register map, field positions and mode codes of the 16-bit waveform generator
package pwmsy_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_OFCON  = 8'h04;
  localparam logic [7:0] OFF_LDCON  = 8'h08;
  localparam logic [7:0] OFF_PHASE  = 8'h0C;
  localparam logic [7:0] OFF_DUTY   = 8'h10;
  localparam logic [7:0] OFF_PERIOD = 8'h14;
  localparam logic [7:0] OFF_OFFSET = 8'h18;
  localparam logic [7:0] OFF_TIMER  = 8'h1C;
  localparam logic [7:0] OFF_CLKCON = 8'h20;
  localparam logic [7:0] OFF_FLAGS  = 8'h24;
  // ==========================================================
  // Field positions
  localparam int CTRL_EN_BIT   = 7;
  localparam int CTRL_OUT_BIT  = 5;
  localparam int CTRL_POL_BIT  = 4;
  localparam int CTRL_MODE_LSB = 2;
  localparam int OFCON_OFM_LSB = 0;
  localparam int OFCON_OFO_BIT = 4;
  localparam int LDCON_LDA_BIT = 7;
  localparam int FLAG_PR_BIT   = 0;
  localparam int FLAG_DC_BIT   = 1;
  localparam int FLAG_PH_BIT   = 2;
  localparam int FLAG_OF_BIT   = 3;
  // ==========================================================
  // Mode codes
  localparam logic [1:0] MODE_STD = 2'h0;
  localparam logic [1:0] MODE_SOM = 2'h1;
  localparam logic [1:0] MODE_TOG = 2'h2;
  localparam logic [1:0] MODE_CEN = 2'h3;
  localparam logic [1:0] OFM_IND  = 2'h0;
  localparam logic [1:0] OFM_SYNC = 2'h1;
  localparam logic [1:0] OFM_ONE  = 2'h2;
  localparam logic [1:0] OFM_CONT = 2'h3;
  // ==========================================================
  // Reset values and bus answers
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [7:0]  PSC_RST  = 8'h00;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;
endpackage

// [test/pwmsy_top_sva.sv]
// Checker for bus handshakes and the load event pulse at the waveform generator ports
`timescale 1ns/100ps
module pwmsy_top_sva
  import pwmsy_pkg::*;
#(
  parameter int CW = 16
) (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        srst,
  // Write side
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Read side
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Events
  input wire logic        load_event
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // ==========================================================
  // Write channel
  property p_b_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("no write answer");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_b_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_b_block: assert property (p_b_block) else $error("write taken while answering");
  property p_w_err;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr > OFF_FLAGS
      |-> ##2 s_axi_bresp == RESP_ERR;
  endproperty
  a_w_err: assert property (p_w_err) else $error("unmapped write not refused");
  // ==========================================================
  // Read channel
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("no read answer");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_r_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_r_block: assert property (p_r_block) else $error("read taken while answering");
  property p_r_err;
    s_axi_arvalid && s_axi_arready && (s_axi_araddr > OFF_FLAGS || s_axi_araddr[1:0] != 2'h0)
      |=> s_axi_rresp == RESP_ERR && s_axi_rdata == 32'h0;
  endproperty
  a_r_err: assert property (p_r_err) else $error("unmapped read not refused");
  // ==========================================================
  // Load pulse: the load clears the arm bit, so a second load needs a new write
  property p_load_pulse;
    load_event |=> !load_event [*2];
  endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("load event repeated");
endmodule
bind pwmsy_top pwmsy_top_sva #(.CW(CW)) pwmsy_top_sva_i (.ref_clk, .srst, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .load_event);

// [test/pwmsy_master_model.sv]
// Master sibling model that emits one-cycle offset hits
`timescale 1ns/100ps
module pwmsy_master_model #(
  parameter int GAP = 100,
  parameter int OFS = 30
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic srst,
  // Control and event
  input  wire logic run,
  output logic      offset_hit
);
  int   cnt_q;
  logic hit_q;
  // Timer restarts from zero whenever run drops, so hit timing is repeatable
  always_ff @(posedge ref_clk) begin
    if (srst || !run) begin
      cnt_q <= 0;
    end else begin
      cnt_q <= (cnt_q == GAP - 1) ? 0 : cnt_q + 1;
    end
  end
  always_ff @(posedge ref_clk) begin
    hit_q <= !srst && run && cnt_q == OFS;
  end
  assign offset_hit = hit_q;
endmodule

// [test/testbench.sv]
// Self-checking bench for the waveform generator
`timescale 1ns/100ps
module testbench;
  import pwmsy_pkg::*;
  // ==========================================================
  // Signals
  logic        ref_clk, srst, group_start_bit, master_run, master_offset_hit;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_v, rd_w;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, offset_hit_event, load_event, pwm_out;
  int          err_total, num_checks, hi, per, n;
  pwmsy_top pwmsy_top_i (.ref_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .group_start_bit,
    .master_offset_hit, .offset_hit_event, .load_event, .pwm_out);
  pwmsy_master_model pwmsy_master_model_i (.ref_clk, .srst, .run(master_run), .offset_hit(master_offset_hit));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd_v = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge ref_clk);
  endtask
  // High time and period of pwm_out, in ref_clk cycles
  task automatic measure();
    n = 0;
    while (pwm_out !== 1'b0 && n < 3000) begin tick(1); n++; end
    while (pwm_out !== 1'b1 && n < 3000) begin tick(1); n++; end
    for (hi = 0; pwm_out === 1'b1 && hi < 3000; hi++) tick(1);
    for (per = hi; pwm_out === 1'b0 && per < 3000; per++) tick(1);
  endtask
  // Cycles from an offset hit pulse to the next rising output
  task automatic ofs_gap();
    for (n = 0; offset_hit_event !== 1'b1 && n < 100; n++) tick(1);
    for (n = 0; pwm_out !== 1'b1 && n < 100; n++) tick(1);
  endtask
  // Module is disabled first, so operating copies follow the buffers
  task automatic setup(input logic [15:0] ph, dc, pr, input logic [7:0] psc, input logic [1:0] slave_sync_select);
    wr(OFF_CTRL, 32'h0);
    wr(OFF_PHASE, {16'h0, ph});
    wr(OFF_DUTY, {16'h0, dc});
    wr(OFF_PERIOD, {16'h0, pr});
    wr(OFF_OFFSET, 32'h4);
    wr(OFF_CLKCON, {24'h0, psc});
    wr(OFF_OFCON, {30'h0, slave_sync_select});
  endtask
  function automatic logic [31:0] ctl(input logic [1:0] m, input logic o);
    return {24'h0, 1'b1, 1'b0, o, 1'b0, m, 2'h0};
  endfunction
  // ==========================================================
  // Tests
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, group_start_bit, master_run, err_total, num_checks} = '0;
    s_axi_wstrb = 4'hF;
    srst = 1'b1;
    tick(20);
    srst <= 1'b0;
    rd(OFF_CTRL); chk(rd_v, 32'h0);
    rd(OFF_PERIOD); chk(rd_v, 32'h0);
    wr(8'h40, 32'h1); chk({30'h0, rsp}, {30'h0, RESP_ERR});
    rd(8'h40); chk({30'h0, rsp}, {30'h0, RESP_ERR});
    wr(OFF_TIMER, 32'h5); rd(OFF_TIMER); chk(rd_v, 32'h0);
    wr(OFF_CTRL, 32'h10); tick(4); chk({31'h0, pwm_out}, 32'h1);
    wr(OFF_CTRL, 32'h0); tick(4); chk({31'h0, pwm_out}, 32'h0);
    $display("test registers and polarity done");
    for (int p = 0; p < 2; p++) begin
      setup(16'h2, 16'h5, 16'h9, 8'(p), OFM_IND);
      wr(OFF_CTRL, ctl(MODE_STD, 1'b0)); tick(30); measure();
      chk(hi, 3 * (p + 1));
      chk(per, 10 * (p + 1));
    end
    rd(OFF_TIMER); chk({31'h0, rd_v <= 32'h9}, 32'h1);
    rd(OFF_FLAGS); chk(rd_v, 32'hF);
    wr(OFF_PERIOD, 32'h13); tick(30); measure(); chk(per, 20);
    wr(OFF_LDCON, 32'h80);
    for (n = 0; load_event !== 1'b1 && n < 500; n++) tick(1);
    tick(2); measure(); chk(per, 40);
    rd(OFF_LDCON); chk(rd_v, 32'h0);
    wr(OFF_CTRL, 32'h0); wr(OFF_FLAGS, 32'hF); rd(OFF_FLAGS); chk(rd_v, 32'h0);
    $display("test standard and reload done");
    setup(16'h2, 16'h5, 16'h9, 8'h0, OFM_IND);
    group_start_bit <= 1'b1; tick(30); measure(); chk(per, 10);
    group_start_bit <= 1'b0;
    setup(16'h0, 16'h5, 16'h9, 8'h0, OFM_IND);
    wr(OFF_CTRL, ctl(MODE_TOG, 1'b0)); tick(30);
    wr(OFF_CTRL, ctl(MODE_TOG, 1'b1)); measure(); chk(hi, 10); chk(per, 20);
    setup(16'h0, 16'h3, 16'h8, 8'h0, OFM_IND);
    wr(OFF_CTRL, ctl(MODE_CEN, 1'b1)); tick(40); measure(); chk(per, 16);
    chk(hi, 5);
    ofs_gap(); chk(n, 2);
    wr(OFF_OFCON, 32'h10); ofs_gap(); chk(n, 2);
    wr(OFF_LDCON, 32'h80); tick(40); ofs_gap(); chk(n, 10);
    $display("test group toggle center done");
    setup(16'h14, 16'h5, 16'h9, 8'h0, OFM_IND);
    wr(OFF_CTRL, ctl(MODE_SOM, 1'b0)); tick(40); chk({31'h0, pwm_out}, 32'h0);
    wr(OFF_CTRL, ctl(MODE_SOM, 1'b1)); tick(4); chk({31'h0, pwm_out}, 32'h1);
    wr(OFF_CTRL, ctl(MODE_SOM, 1'b0)); tick(4); chk({31'h0, pwm_out}, 32'h0);
    setup(16'h3, 16'h5, 16'h9, 8'h0, OFM_IND);
    wr(OFF_CTRL, ctl(MODE_SOM, 1'b0)); tick(20);
    for (n = 0; n < 30 && pwm_out === 1'b1; n++) tick(1);
    chk(n, 30);
    rd(OFF_CTRL); chk({31'h0, rd_v[CTRL_OUT_BIT]}, 32'h1);
    wr(OFF_CTRL, 32'h0); tick(4); chk({31'h0, pwm_out}, 32'h0);
    $display("test set on match done");
    // Phase count kept at 1 or more so continuous slave runs a duty
    for (int m = 1; m < 4; m++) begin
      setup(16'h1, 16'h5, 16'h9, 8'h0, 2'(m));
      wr(OFF_CTRL, ctl(MODE_STD, 1'b0)); tick(10);
      rd(OFF_TIMER); chk(rd_v, 32'h0);
      master_run <= 1'b1;
      for (n = 0; master_offset_hit !== 1'b1 && n < 300; n++) tick(1);
      master_run <= 1'b0; tick(4);
      rd(OFF_TIMER); chk({31'h0, rd_v != 32'h0}, 32'h1);
      tick(40); rd(OFF_TIMER); rd_w = rd_v; rd(OFF_TIMER);
      chk({31'h0, rd_v !== rd_w}, {31'h0, 2'(m) != OFM_ONE});
      if (2'(m) == OFM_ONE) chk(rd_v, 32'h0);
    end
    // Reads ten cycles apart span one period, so a kept timer reads the same
    rd(OFF_TIMER); rd_w = rd_v; wr(OFF_OFCON, 32'h0); tick(3);
    rd(OFF_TIMER); chk(rd_v, rd_w);
    $display("test offset modes done");
    finish_test();
  end
  initial begin
    tick(40000);
    err_total++;
    finish_test();
  end
endmodule
